// ---- logic/codec_control_core.sv ----
// Operation
// - Non-delayed: receive sync marks the slot start.
// - Delayed: sync marks frame, counter finds slot.
// - Receive data sampled only in assigned slot.
// - Each latch pin direction set by direction bit.
// - Input latch pins captured on each control byte.
// - Output latch pins driven from content register.
// - Control bits move only with chip select low.
// - Command taken and readback shown while selected.
// - Chip select high means no control transfer.
// - Hard reset high restores every register.
// - Power-on reset leaves device powered down.
// - Reset: gains zero, amplifier off, non-delayed.
// - Reset: all latch pins inputs, floating.
// - Reset: readback output tri-stated.
// - Power-down bit in any instruction obeyed.
// - Powered down: transmit outputs high impedance.
// - Power-down keeps registers, port and latches.
// - Encode cycle starts right after transmit slot.
// - Transmit byte shifted on eight rising edges.
// - Transmit stays off until second sync after power-up.
// - Chip select high tri-states readback output.
// - Command bit sampled on control clock falling edge.
// - Power bit zero powers up, one powers down.
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_cfg.svh"

module codec_control_core
  import codec_ctrl_pkg::*;
#(
  parameter int LATCH_W = 6
)(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  input  wire logic               bit_clock,
  input  wire logic               receive_frame_sync,
  input  wire logic               transmit_frame_sync,
  input  wire logic               receive_data_in_a,
  input  wire logic               receive_data_in_b,
  input  wire logic [7:0]         tx_pcm_byte,
  output logic                    transmit_data_out_a,
  output logic                    transmit_data_oe_a,
  output logic                    transmit_data_out_b,
  output logic                    transmit_data_oe_b,
  output logic                    encode_start,
  output logic      [7:0]         rx_pcm_byte,
  output logic                    decode_start,
  input  wire logic               control_clock,
  input  wire logic               chip_select_n,
  input  wire logic               serial_command_in,
  output logic                    serial_readback_out,
  output logic                    serial_readback_oe,
  input  wire logic               hard_reset_in,
  input  wire logic [LATCH_W-1:0] interface_latch_pin_in,
  output logic      [LATCH_W-1:0] interface_latch_pin_out,
  output logic      [LATCH_W-1:0] interface_latch_pin_oe,
  output logic                    power_down,
  output logic                    power_amp_enable,
  output logic                    alaw_select,
  output logic      [7:0]         tx_gain,
  output logic      [7:0]         rx_gain
);

  // Whole state of the control side in one record.
  typedef struct packed {
    port_phase_t        phase;     // Where the serial port is in an instruction.
    logic               control_clock_d;    // Control clock level on the last cycle.
    logic [2:0]         bitcnt;    // Bits received in the current byte.
    logic [7:0]         shin;      // Input shift register.
    logic [3:0]         op;        // Register selector of the pending instruction.
    logic [7:0]         shout;     // Readback shift register.
    logic               co;        // Readback data level.
    logic               co_oe;     // Readback drive enable.
    logic               pd;        // Powered down.
    logic               amp;       // Receive power amplifier enable.
    logic               rst_seen;  // Reset request for the link side.
    logic [7:0]         ctrl;      // Control register.
    logic [LATCH_W-1:0] latch_direction_reg;       // Latch direction, 1 drives the pin.
    logic [LATCH_W-1:0] latch_content_reg;       // Latch content.
    logic [7:0]         tx_slot;   // Transmit slot and port.
    logic [7:0]         rx_slot;   // Receive slot and port.
    logic [7:0]         txg;       // Transmit gain code.
    logic [7:0]         rxg;       // Receive gain code.
  } ctl_t;

  ctl_t               cur_ff;      // Registered state.
  ctl_t               nxt_ff;      // Next state.
  logic [LATCH_W+3:0] pins_s;      // Synchronised pins.
  logic               hr_s;        // Synchronised hard reset.
  logic               control_clock_s;      // Synchronised control clock.
  logic               cs_n_s;      // Synchronised chip select, low active.
  logic               ci_s;        // Synchronised command bit.
  logic [LATCH_W-1:0] latch_s;     // Synchronised latch pin levels.
  logic               control_clock_rise;   // Control clock rose.
  logic               control_clock_fall;   // Control clock fell.
  logic [7:0]         shin_n;      // Input register after this bit.
  logic [LATCH_W-1:0] ilr_cap;     // Content with input pins refreshed.
  logic               bit_clock_n; // Falling-edge clock for receive.

  // Readback value of a register; unknown selectors read as zero.
  function automatic logic [7:0] reg_read(input logic [3:0] op, input ctl_t s,
                                          input logic [LATCH_W-1:0] latch_content_reg);
    logic [7:0] v;
    v = `RST_BYTE;
    case (op)
      `OP_CTRL:    v = s.ctrl;
      `OP_LDR:     v = 8'(s.latch_direction_reg);
      `OP_ILR:     v = 8'(latch_content_reg);
      `OP_TX_SLOT: v = s.tx_slot;
      `OP_RX_SLOT: v = s.rx_slot;
      `OP_TX_GAIN: v = s.txg;
      `OP_RX_GAIN: v = s.rxg;
      default:     v = `RST_BYTE;
    endcase
    return v;
  endfunction : reg_read

  // All control pins and latch pins arrive asynchronously, so each takes two stages.
  sync2 #(.WIDTH(LATCH_W + 4)) u_pin_sync (
    .clk      (sys_clk),
    .async_in ({hard_reset_in, control_clock, chip_select_n, serial_command_in,
                interface_latch_pin_in}),
    .sync_out (pins_s)
  );

  assign hr_s    = pins_s[LATCH_W+3];
  assign control_clock_s  = pins_s[LATCH_W+2];
  assign cs_n_s  = pins_s[LATCH_W+1];
  assign ci_s    = pins_s[LATCH_W];
  assign latch_s = pins_s[LATCH_W-1:0];

  // Receive samples on falling bit clock edges, so its engine runs on the inverse.
  assign bit_clock_n = ~bit_clock;

  // Transmit direction: shifts on rising edges and paces the encoder.
  pcm_slot_engine #(.IS_TX(1'b1)) u_tx (
    .link_clk   (bit_clock),
    .req_rst    (cur_ff.rst_seen),
    .req_ce     (clk_en),
    .req_pd     (cur_ff.pd),
    .req_dly    (cur_ff.ctrl[`CTRL_DELAYED_BIT]),
    .req_slot   (cur_ff.tx_slot[`SLOT_NUM_HI:0]),
    .req_port   (cur_ff.tx_slot[`SLOT_PORT_BIT]),
    .frame_sync (transmit_frame_sync),
    .data_in_a  (1'b0),
    .data_in_b  (1'b0),
    .tx_byte    (tx_pcm_byte),
    .data_out_a (transmit_data_out_a),
    .data_oe_a  (transmit_data_oe_a),
    .data_out_b (transmit_data_out_b),
    .data_oe_b  (transmit_data_oe_b),
    .byte_out   (),
    .slot_done  (encode_start)
  );

  // Receive direction: samples the assigned port and hands bytes to the decoder.
  pcm_slot_engine #(.IS_TX(1'b0)) u_rx (
    .link_clk   (bit_clock_n),
    .req_rst    (cur_ff.rst_seen),
    .req_ce     (clk_en),
    .req_pd     (cur_ff.pd),
    .req_dly    (cur_ff.ctrl[`CTRL_DELAYED_BIT]),
    .req_slot   (cur_ff.rx_slot[`SLOT_NUM_HI:0]),
    .req_port   (cur_ff.rx_slot[`SLOT_PORT_BIT]),
    .frame_sync (receive_frame_sync),
    .data_in_a  (receive_data_in_a),
    .data_in_b  (receive_data_in_b),
    .tx_byte    (`RST_BYTE),
    .data_out_a (),
    .data_oe_a  (),
    .data_out_b (),
    .data_oe_b  (),
    .byte_out   (rx_pcm_byte),
    .slot_done  (decode_start)
  );

  // Serial port sequencing, register writes and readback.
  always_comb
  begin
    nxt_ff           = cur_ff;
    nxt_ff.rst_seen  = 1'b0;
    nxt_ff.control_clock_d    = control_clock_s;
    control_clock_rise        = control_clock_s & ~cur_ff.control_clock_d;
    control_clock_fall        = ~control_clock_s & cur_ff.control_clock_d;
    shin_n           = {cur_ff.shin[6:0], ci_s};
    // Input pins overwrite their content bits; output pins keep theirs.
    ilr_cap          = (cur_ff.latch_content_reg & cur_ff.latch_direction_reg) | (latch_s & ~cur_ff.latch_direction_reg);
    // The amplifier only runs while powered up.
    nxt_ff.amp       = ~cur_ff.pd;
    if (cs_n_s)
    begin
      // Deselected: the bit count restarts and readback floats.
      nxt_ff.bitcnt = 3'h0;
      nxt_ff.co_oe  = 1'b0;
    end
    else
    begin
      // Readback drives only while selected and inside a read byte.
      nxt_ff.co_oe = (cur_ff.phase == PH_READ);
      if (control_clock_rise && cur_ff.phase == PH_READ)
      begin
        nxt_ff.co    = cur_ff.shout[7];
        nxt_ff.shout = {cur_ff.shout[6:0], 1'b0};
      end
      if (control_clock_fall)
      begin
        nxt_ff.shin   = shin_n;
        nxt_ff.bitcnt = cur_ff.bitcnt + 3'h1;
        if (cur_ff.bitcnt == `BIT_LAST)
        begin
          // Every completed byte refreshes the input latches.
          nxt_ff.latch_content_reg = ilr_cap;
          case (cur_ff.phase)
            PH_FIRST:
            begin
              // The power bit counts in every first byte, short or long.
              nxt_ff.pd = shin_n[`CMD_PWR_BIT];
              nxt_ff.op = shin_n[`CMD_OP_HI:`CMD_OP_LO];
              if (shin_n[`CMD_LONG_BIT] && shin_n[`CMD_READ_BIT])
              begin
                nxt_ff.phase = PH_READ;
                nxt_ff.shout = reg_read(shin_n[`CMD_OP_HI:`CMD_OP_LO], cur_ff, ilr_cap);
              end
              else if (shin_n[`CMD_LONG_BIT])
              begin
                nxt_ff.phase = PH_WRITE;
              end
              else
              begin
                nxt_ff.phase = PH_FIRST;
              end
            end
            PH_WRITE:
            begin
              // Writes land only here, so power-down leaves all registers alone.
              case (cur_ff.op)
                `OP_CTRL:    nxt_ff.ctrl    = shin_n;
                `OP_LDR:     nxt_ff.latch_direction_reg     = shin_n[LATCH_W-1:0];
                `OP_ILR:     nxt_ff.latch_content_reg     = (shin_n[LATCH_W-1:0] & cur_ff.latch_direction_reg)
                                              | (latch_s & ~cur_ff.latch_direction_reg);
                `OP_TX_SLOT: nxt_ff.tx_slot = shin_n;
                `OP_RX_SLOT: nxt_ff.rx_slot = shin_n;
                `OP_TX_GAIN: nxt_ff.txg     = shin_n;
                `OP_RX_GAIN: nxt_ff.rxg     = shin_n;
                default:     nxt_ff.ctrl    = cur_ff.ctrl;
              endcase
              nxt_ff.phase = PH_FIRST;
            end
            PH_READ:
            begin
              nxt_ff.phase = PH_FIRST;
            end
            default:
            begin
              nxt_ff.phase = PH_FIRST;
            end
          endcase
        end
      end
    end
  end

  // Either reset restores the power-on picture; otherwise the enable gates every update.
  always_ff @(posedge sys_clk)
  begin
    if (rst || hr_s)
    begin
      cur_ff          <= '0;
      cur_ff.phase    <= PH_FIRST;
      cur_ff.pd       <= `RST_PWR_DOWN;
      cur_ff.ctrl     <= `RST_BYTE;
      cur_ff.txg      <= `RST_BYTE;
      cur_ff.rxg      <= `RST_BYTE;
      cur_ff.amp      <= 1'b0;
      cur_ff.latch_direction_reg      <= '0;
      cur_ff.co_oe    <= 1'b0;
      cur_ff.control_clock_d   <= 1'b0;
      cur_ff.rst_seen <= 1'b1;
    end
    else if (clk_en)
    begin
      cur_ff <= nxt_ff;
    end
  end

  // Every output is a field of the registered state.
  assign serial_readback_out     = cur_ff.co;
  assign serial_readback_oe      = cur_ff.co_oe;
  assign interface_latch_pin_out = cur_ff.latch_content_reg;
  assign interface_latch_pin_oe  = cur_ff.latch_direction_reg;
  assign power_down              = cur_ff.pd;
  assign power_amp_enable        = cur_ff.amp;
  assign alaw_select             = cur_ff.ctrl[`CTRL_LAW_BIT];
  assign tx_gain                 = cur_ff.txg;
  assign rx_gain                 = cur_ff.rxg;

endmodule : codec_control_core

`default_nettype wire

// ---- logic/codec_ctrl_cfg.svh ----
`ifndef CODEC_CTRL_CFG_SVH
`define CODEC_CTRL_CFG_SVH

// Instruction byte fields, bit 7 is shifted first.
`define CMD_PWR_BIT       7
`define CMD_OP_HI         6
`define CMD_OP_LO         3
`define CMD_READ_BIT      2
`define CMD_LONG_BIT      1

// Register selector codes held in instruction bits 6 to 3.
`define OP_CTRL           4'h0
`define OP_LDR            4'h2
`define OP_ILR            4'h1
`define OP_TX_SLOT        4'hA
`define OP_RX_SLOT        4'h9
`define OP_TX_GAIN        4'h5
`define OP_RX_GAIN        4'h4

// Field positions inside the control and slot registers.
`define CTRL_DELAYED_BIT  3
`define CTRL_LAW_BIT      5
`define SLOT_NUM_HI       5
`define SLOT_PORT_BIT     6

// Reset values.
`define RST_BYTE          8'h00
`define RST_PWR_DOWN      1'b1

// Counting constants.
`define BIT_LAST          3'h7
`define FS_OPEN_COUNT     2'h2
`define FRAME_BIT_LAST    9'h1FF
`define SLOT_FIRST        6'h00

`endif

// ---- logic/codec_ctrl_pkg.sv ----
package codec_ctrl_pkg;

  // Serial port phases, one-hot.
  typedef enum logic [2:0] {
    PH_FIRST = 3'h1,
    PH_WRITE = 3'h2,
    PH_READ  = 3'h4
  } port_phase_t;

  // Two-stage synchroniser contents.
  typedef struct packed {
    logic [31:0] meta;
    logic [31:0] safe;
  } sync_word_t;

endpackage : codec_ctrl_pkg

// ---- logic/pcm_slot_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_cfg.svh"

// Slot timing for one PCM direction, clocked by the link edge that direction uses.
module pcm_slot_engine
  import codec_ctrl_pkg::*;
#(
  parameter bit IS_TX = 1'b1
)(
  input  wire logic       link_clk,
  input  wire logic       req_rst,
  input  wire logic       req_ce,
  input  wire logic       req_pd,
  input  wire logic       req_dly,
  input  wire logic [5:0] req_slot,
  input  wire logic       req_port,
  input  wire logic       frame_sync,
  input  wire logic       data_in_a,
  input  wire logic       data_in_b,
  input  wire logic [7:0] tx_byte,
  output logic            data_out_a,
  output logic            data_oe_a,
  output logic            data_out_b,
  output logic            data_oe_b,
  output logic      [7:0] byte_out,
  output logic            slot_done
);

  typedef struct packed {
    logic       fs1;     // Frame sync one edge ago.
    logic       fs2;     // Frame sync two edges ago.
    logic       dly;     // Latched delayed-timing mode.
    logic [5:0] slot;    // Latched slot number.
    logic       port;    // Latched port, 1 selects port b.
    logic [1:0] fscnt;   // Frame syncs seen since power-up.
    logic       run;     // Bit position is counting.
    logic [8:0] pos;     // Bit position within the frame.
    logic       act;     // Slot was active on the last edge.
    logic [7:0] sh;      // Receive shift register.
    logic       out_a;
    logic       oe_a;
    logic       out_b;
    logic       oe_b;
    logic [7:0] rbyte;   // Last complete receive byte.
    logic       done;    // One-edge pulse after the slot.
  } eng_t;

  eng_t       cur_ff;    // Registered state.
  eng_t       nxt_ff;    // Next state.
  logic [10:0] req_s;    // Synchronised requests.
  logic       start_nd;  // Sync edge seen on this edge.
  logic       start_d;   // Sync edge seen on the previous edge.
  logic       fstart;    // Frame or slot origin on this edge.
  logic [8:0] npos;      // Position valid on this edge.
  logic       nrun;      // Counter running on this edge.
  logic       active;    // Inside the assigned slot on this edge.
  logic       din;       // Data from the selected port.

  // Requests come from the system clock and cross through two stages.
  sync2 #(.WIDTH(11)) u_req_sync (
    .clk      (link_clk),
    .async_in ({req_rst, req_ce, req_pd, req_dly, req_slot, req_port}),
    .sync_out (req_s)
  );

  // Slot position, data shifting and output enables.
  always_comb
  begin
    nxt_ff   = cur_ff;
    nxt_ff.fs1 = frame_sync;
    nxt_ff.fs2 = cur_ff.fs1;
    start_nd = frame_sync & ~cur_ff.fs1;
    start_d  = cur_ff.fs1 & ~cur_ff.fs2;
    fstart   = cur_ff.dly ? start_d : start_nd;
    npos     = fstart ? 9'h000 : cur_ff.pos + 9'h001;
    nrun     = fstart | (cur_ff.run & (cur_ff.pos != `FRAME_BIT_LAST));
    // Delayed timing counts slots from the frame origin; otherwise the origin is the slot.
    active   = nrun & (npos[8:3] == (cur_ff.dly ? cur_ff.slot : `SLOT_FIRST));
    din      = cur_ff.port ? data_in_b : data_in_a;
    nxt_ff.run  = nrun;
    nxt_ff.pos  = npos;
    nxt_ff.act  = active;
    nxt_ff.done = cur_ff.act & ~active;
    // Settings are taken only while powered down, when the host keeps them still.
    if (req_s[8])
    begin
      nxt_ff.dly  = req_s[7];
      nxt_ff.slot = req_s[6:1];
      nxt_ff.port = req_s[0];
      nxt_ff.fscnt = 2'h0;
    end
    else if (start_nd && cur_ff.fscnt != `FS_OPEN_COUNT)
    begin
      nxt_ff.fscnt = cur_ff.fscnt + 2'h1;
    end
    if (IS_TX)
    begin
      // Drive only in the slot, powered, and after the second sync.
      nxt_ff.out_a = tx_byte[~npos[2:0]];
      nxt_ff.out_b = tx_byte[~npos[2:0]];
      nxt_ff.oe_a  = active & ~req_s[8] & (nxt_ff.fscnt == `FS_OPEN_COUNT)
                     & ~cur_ff.port;
      nxt_ff.oe_b  = active & ~req_s[8] & (nxt_ff.fscnt == `FS_OPEN_COUNT)
                     & cur_ff.port;
    end
    else
    begin
      // Incoming levels are ignored outside the assigned slot and port.
      if (active)
      begin
        nxt_ff.sh = {cur_ff.sh[6:0], din};
      end
      if (nxt_ff.done)
      begin
        nxt_ff.rbyte = cur_ff.sh;
      end
    end
  end

  // Reset and clock enable both arrive synchronised from the system side.
  always_ff @(posedge link_clk)
  begin
    if (req_s[10])
    begin
      cur_ff      <= '0;
    end
    else if (req_s[9])
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign data_out_a = cur_ff.out_a;
  assign data_oe_a  = cur_ff.oe_a;
  assign data_out_b = cur_ff.out_b;
  assign data_oe_b  = cur_ff.oe_b;
  assign byte_out   = cur_ff.rbyte;
  assign slot_done  = cur_ff.done;

endmodule : pcm_slot_engine

`default_nettype wire

// ---- logic/sync2.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser; only the second stage is ever read.
module sync2
  import codec_ctrl_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  sync_word_t cur_ff;   // Both stages, padded to 32 bits.
  sync_word_t nxt_ff;   // Next value of both stages.

  // Stage one takes the pin, stage two takes stage one.
  always_comb
  begin
    nxt_ff      = cur_ff;
    nxt_ff.meta = 32'(async_in);
    nxt_ff.safe = cur_ff.meta;
  end

  // No reset: the stages flush within two edges anyway.
  always_ff @(posedge clk)
  begin
    cur_ff <= nxt_ff;
  end

  assign sync_out = cur_ff.safe[WIDTH-1:0];

endmodule : sync2

`default_nettype wire

// ---- test/codec_ctrl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port checker for the control core; link checks run on the rising bit clock.
module codec_ctrl_monitor #(
  parameter int LATCH_W = 6
)(
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               bit_clock,
  input wire logic               chip_select_n,
  input wire logic               hard_reset_in,
  input wire logic               serial_readback_oe,
  input wire logic               power_down,
  input wire logic               power_amp_enable,
  input wire logic [7:0]         tx_gain,
  input wire logic [LATCH_W-1:0] interface_latch_pin_oe,
  input wire logic               transmit_data_oe_a,
  input wire logic               transmit_data_oe_b,
  input wire logic               encode_start
);
  wire logic oe_any; // High while either transmit port drives.
  assign oe_any = transmit_data_oe_a | transmit_data_oe_b;
  a_reset_state: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> power_down && !power_amp_enable && !serial_readback_oe
    && tx_gain == 8'h00 && !(|interface_latch_pin_oe)) else $error("reset values wrong");
  a_amp_off: assert property (@(posedge sys_clk) disable iff (rst)
    power_down |=> !power_amp_enable) else $error("amplifier on while down");
  // Four samples cover the two synchroniser stages plus the register update.
  a_hard_reset: assert property (@(posedge sys_clk) disable iff (rst)
    hard_reset_in [*4] |=> power_down && tx_gain == 8'h00 && !(|interface_latch_pin_oe))
    else $error("hard reset ignored");
  a_cs_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    chip_select_n [*5] |-> !serial_readback_oe) else $error("readback driven unselected");
  a_cs_frozen: assert property (@(posedge sys_clk) disable iff (rst)
    (chip_select_n && !hard_reset_in) [*6] |=> $stable(power_down) && $stable(tx_gain)
    && $stable(interface_latch_pin_oe)) else $error("state moved unselected");
  a_tx_off_down: assert property (@(posedge bit_clock) disable iff (rst)
    power_down [*6] |-> !oe_any) else $error("transmit driven while down");
  a_one_port: assert property (@(posedge bit_clock) disable iff (rst)
    !(transmit_data_oe_a && transmit_data_oe_b)) else $error("both ports driven");
  a_slot_len: assert property (@(posedge bit_clock) disable iff (rst)
    $rose(oe_any) |-> oe_any [*8] ##1 (!oe_any && encode_start)) else $error("bad slot");
endmodule : codec_ctrl_monitor
`default_nettype wire

// ---- test/ctrl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host on the serial control port; it moves its lines just after sys_clk edges.
module ctrl_host_model (
  input  wire logic sys_clk,
  output logic      control_clock,
  output logic      chip_select_n,
  output logic      serial_command_in,
  input  wire logic serial_readback_out
);
  initial
  begin
    control_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_command_in = 1'b0;
  end
  // One byte per select pulse, first bit 7; five-cycle phases clear the synchroniser.
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    chip_select_n <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      repeat (5) @(posedge sys_clk);
      control_clock <= 1'b1;
      serial_command_in <= d[i];
      repeat (5) @(posedge sys_clk);
      q[i] = serial_readback_out;
      control_clock <= 1'b0;
    end
    repeat (5) @(posedge sys_clk);
    chip_select_n <= 1'b1;
    serial_command_in <= ~d[0]; // Idle line flips so a stale bit is never reused.
    repeat (6) @(posedge sys_clk);
  endtask : xfer
endmodule : ctrl_host_model
`default_nettype wire

// ---- test/test_codec_control_and_latch_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_codec_control_and_latch_logic import codec_ctrl_pkg::*;;
  typedef struct packed {
    logic [3:0] op;
    logic [7:0] wd;
    logic [7:0] ex;
    logic [7:0] mk;
  } row_t;
  // Write then read each register; input latch bits read back as the pin levels.
  row_t rows [7] = '{'{4'h2, 8'h15, 8'h15, 8'h3F}, '{4'h1, 8'h0F, 8'h2F, 8'h3F},
    '{4'h5, 8'hA5, 8'hA5, 8'hFF}, '{4'h4, 8'h5A, 8'h5A, 8'hFF},
    '{4'hA, 8'h42, 8'h42, 8'h7F}, '{4'h9, 8'h03, 8'h03, 8'h7F}, '{4'h0, 8'h28, 8'h28, 8'h28}};
  localparam logic [7:0] RX_REF = 8'hC3;
  logic       sys_clk = 1'b0, bit_clock = 1'b0, rst = 1'b1, hard_reset_in = 1'b0;
  logic       receive_frame_sync = 1'b0, transmit_frame_sync = 1'b0;
  logic       receive_data_in_a = 1'b0, receive_data_in_b = 1'b0;
  logic       transmit_data_out_a, transmit_data_oe_a, transmit_data_out_b, transmit_data_oe_b;
  logic       encode_start, decode_start, serial_readback_out, serial_readback_oe;
  logic       power_down, power_amp_enable, alaw_select;
  logic [7:0] rx_pcm_byte, tx_gain, rx_gain, q;
  logic [5:0] interface_latch_pin_out, interface_latch_pin_oe;
  wire        control_clock, chip_select_n, serial_command_in;
  int         fails = 0, total_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  always #6 bit_clock = ~bit_clock;
  codec_control_core codec_control_core_inst (.sys_clk, .rst, .clk_en(1'b1), .bit_clock,
    .receive_frame_sync, .transmit_frame_sync, .receive_data_in_a, .receive_data_in_b,
    .tx_pcm_byte(8'hB4), .transmit_data_out_a, .transmit_data_oe_a, .transmit_data_out_b,
    .transmit_data_oe_b, .encode_start, .rx_pcm_byte, .decode_start, .control_clock,
    .chip_select_n, .serial_command_in, .serial_readback_out, .serial_readback_oe,
    .hard_reset_in, .interface_latch_pin_in(6'h2A), .interface_latch_pin_out,
    .interface_latch_pin_oe, .power_down, .power_amp_enable, .alaw_select, .tx_gain, .rx_gain);
  ctrl_host_model ctrl_host_model_inst (.sys_clk, .control_clock, .chip_select_n,
    .serial_command_in, .serial_readback_out);
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : check
  // Two-byte instruction; P stays 1 so all setup happens powered down.
  task automatic cmd(input logic [3:0] op, input logic rd, input logic [7:0] d);
    ctrl_host_model_inst.xfer({1'b1, op, rd, 2'b10}, q);
    ctrl_host_model_inst.xfer(d, q);
  endtask : cmd
  // One frame; off-slot bits toggle so a wrong sampling window corrupts the byte.
  task automatic frame(input int toff, input int roff, input logic on);
    int n;
    int first;
    int d;
    logic [7:0] b;
    n = 0;
    first = 0;
    d = 0;
    b = 8'h00;
    for (int i = 0; i < 48; i++)
    begin
      @(posedge bit_clock);
      // The decode pulse moves on falling edges, so it is settled here.
      d = d + int'(decode_start === 1'b1);
      transmit_frame_sync <= (i == 0);
      receive_frame_sync <= (i == 0);
      receive_data_in_a <= (i >= roff && i < roff + 8) ? RX_REF[roff + 7 - i] : i[0];
      receive_data_in_b <= ~i[0];
      @(negedge bit_clock);
      if (transmit_data_oe_b === 1'b1)
      begin
        first = (n == 0) ? i : first;
        b = {b[6:0], transmit_data_out_b};
        n++;
      end
    end
    check("tx count", 16'(n), on ? 16'h0008 : 16'h0000);
    if (on)
    begin
      check("tx byte", b, 8'hB4);
      check("tx start", 16'(first), 16'(toff));
      check("rx byte", rx_pcm_byte, RX_REF);
      check("rx done", 16'(d), 16'h0001);
    end
  endtask : frame
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("reset", {power_down, power_amp_enable, serial_readback_oe}, 16'h0004);
    check("reset regs", {alaw_select, 1'b0, interface_latch_pin_oe, tx_gain | rx_gain},
      16'h0000);
    foreach (rows[i])
    begin
      cmd(rows[i].op, 1'b0, rows[i].wd);
      cmd(rows[i].op, 1'b1, 8'h00);
      check("readback", q & rows[i].mk, rows[i].ex & rows[i].mk);
    end
    check("latch dir", interface_latch_pin_oe, 16'h0015);
    check("latch out", interface_latch_pin_out & interface_latch_pin_oe, 16'h0005);
    check("law", alaw_select, 16'h0001);
    frame(0, 0, 1'b0);
    ctrl_host_model_inst.xfer(8'h00, q); // Single-byte power-up.
    check("power", {power_down, power_amp_enable}, 16'h0001);
    frame(0, 0, 1'b0);
    frame(18, 25, 1'b1);
    cmd(4'h0, 1'b0, 8'h20); // Power-down rides on a control write.
    check("retained", {power_down, 1'b0, interface_latch_pin_oe, tx_gain}, 16'h95A5);
    ctrl_host_model_inst.xfer(8'h00, q);
    frame(0, 0, 1'b0);
    frame(1, 0, 1'b1);
    hard_reset_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    hard_reset_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("hard reset", {power_down, 1'b0, interface_latch_pin_oe, tx_gain}, 16'h8000);
    report_and_stop();
  end
  // The run needs about 80 us; far beyond that means a hang.
  initial
  begin
    #300us;
    fails++;
    report_and_stop();
  end
endmodule : test_codec_control_and_latch_logic
bind codec_control_core codec_ctrl_monitor #(.LATCH_W(LATCH_W)) codec_ctrl_monitor_inst (
  .sys_clk, .rst, .bit_clock, .chip_select_n, .hard_reset_in, .serial_readback_oe,
  .power_down, .power_amp_enable, .tx_gain, .interface_latch_pin_oe, .transmit_data_oe_a,
  .transmit_data_oe_b, .encode_start);
`default_nettype wire
